/* File: alc_defines.svh */
// Purpose: Offsets, field positions, reset values and timing figures of the level control block
// Assumes: Register addresses are the 7-bit control port addresses
// Notes:   Definitions only
`ifndef ALC_DEFINES_SVH
`define ALC_DEFINES_SVH

`define ALC_ADDR_W           7
`define ALC_ADDR_MODE_CFG    7'h7B
`define ALC_ADDR_THR_TIMES   7'h7C
`define ALC_ADDR_RESTART     7'h7D

`define ALC_MODE_RST         8'h00
`define ALC_THR_RST          8'h00

`define ALC_RATE_POS         6
`define ALC_LIMIT_POS        4
`define ALC_RECOVERY_POS     2
`define ALC_POLICY_POS       1
`define ALC_ENABLE_POS       0
`define ALC_RSVD_POS         7
`define ALC_REC_THR_POS      5
`define ALC_ATK_THR_POS      3
`define ALC_REC_TIME_POS     1
`define ALC_ATK_TIME_POS     0

// Sample rates in kHz, samples per millisecond
`define ALC_RATE_96_KHZ      15'h0060
`define ALC_RATE_48_KHZ      15'h0030
`define ALC_RATE_32_KHZ      15'h0020

// Times in ms
`define ALC_ATK_SHORT_MS     15'h0001
`define ALC_ATK_LONG_MS      15'h0004
`define ALC_REC_32_MS        15'h0020
`define ALC_REC_64_MS        15'h0040
`define ALC_REC_128_MS       15'h0080
`define ALC_REC_256_MS       15'h0100

// Limited recovery step limits
`define ALC_LIMIT_3          5'h03
`define ALC_LIMIT_7          5'h07
`define ALC_LIMIT_15         5'h0F
`define ALC_LIMIT_31         5'h1F

// Threshold magnitudes in dB below full scale
`define ALC_ATK_THR_0_DB     8'h00
`define ALC_ATK_THR_1_DB     8'h01
`define ALC_ATK_THR_2_DB     8'h02
`define ALC_ATK_THR_4_DB     8'h04
`define ALC_REC_THR_2_DB     8'h02
`define ALC_REC_THR_3_DB     8'h03
`define ALC_REC_THR_4_DB     8'h04
`define ALC_REC_THR_6_DB     8'h06

`endif

/* File: alc_pkg.sv */
// Purpose: Types shared by the level control files
// Assumes: Field layout in alc_defines.svh
// Notes:   Struct field order mirrors the register bit order
package alc_pkg;

   typedef enum logic [1:0] {
      ALC_REC_NONE    = 2'h0,
      ALC_REC_NORMAL  = 2'h1,
      ALC_REC_LIMITED = 2'h2,
      ALC_REC_RSVD    = 2'h3
   } alc_recovery_e;

   typedef enum logic [1:0] {
      ALC_ST_OFF       = 2'h0,
      ALC_ST_RUN       = 2'h1,
      ALC_ST_EXHAUSTED = 2'h3
   } alc_state_e;

   typedef struct packed {
      logic [1:0]   adc_rate_select;
      logic [1:0]   recovery_count_limit;
      alc_recovery_e recovery_mode_select;
      logic         channel_detect_policy;
      logic         level_ctrl_enable;
   } alc_mode_cfg_s;

   typedef struct packed {
      logic         reserved;
      logic [1:0]   recovery_threshold;
      logic [1:0]   attack_threshold;
      logic [1:0]   recovery_time_select;
      logic         attack_time_select;
   } alc_thr_cfg_s;

endpackage

/* File: alc_timer.sv */
// Purpose: Counts sample ticks while a condition holds, pulses at target
// Assumes: tick_i is a one-cycle sample strobe on core_clk_i
// Notes:   Condition dropping restarts the count from zero
`timescale 1ns/1ps
`default_nettype none
module alc_timer #(
   parameter int CNT_W = 15
) (
   // Clock and reset
   input  wire logic             core_clk_i,
   input  wire logic             sys_rst_i,
   // Control
   input  wire logic             clr_i,
   input  wire logic             run_i,
   input  wire logic             tick_i,
   input  wire logic [CNT_W-1:0] target_i,
   // Result
   output logic                  done_o
);
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic             done_q, done_d;

   always_comb begin
      cnt_d  = cnt_q;
      done_d = 1'b0;
      if (clr_i || !run_i) begin
         cnt_d = '0;
      end else if (tick_i) begin
         if (cnt_q + CNT_W'(1) >= target_i) begin
            cnt_d  = '0;
            done_d = 1'b1;
         end else begin
            cnt_d = cnt_q + CNT_W'(1);
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         cnt_q  <= '0;
         done_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         done_q <= done_d;
      end
   end

   assign done_o = done_q;
endmodule
`default_nettype wire

/* File: alc_regs.sv */
// Purpose: Control registers and gain control of the record channel level control
// Assumes: Channel levels arrive as dB below full scale, one strobe per ADC sample
// Notes:   Read data appears one cycle after the read strobe
`include "alc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module alc_regs
   import alc_pkg::*;
#(
   parameter int         TIME_SHIFT = 0,
   parameter logic [7:0] GAIN_MAX   = 8'hFF
) (
   // Clock and reset
   input  wire logic                  core_clk_i,
   input  wire logic                  sys_rst_i,
   // Control port
   input  wire logic                  wr_en_i,
   input  wire logic                  rd_en_i,
   input  wire logic [`ALC_ADDR_W-1:0] addr_i,
   input  wire logic [7:0]            wdata_i,
   output logic      [7:0]            rdata_o,
   // Level detectors
   input  wire logic                  sample_stb_i,
   input  wire logic [7:0]            left_level_i,
   input  wire logic [7:0]            right_level_i,
   // Gain control
   output logic      [7:0]            gain_reduction_o,
   output logic                       level_ctrl_active_o
);
   alc_mode_cfg_s mode_q, mode_d;
   alc_thr_cfg_s  thr_q, thr_d;
   alc_state_e    st_q, st_d;
   logic [7:0]    gain_q, gain_d;
   logic [4:0]    steps_q, steps_d;
   logic [7:0]    rdata_q, rdata_d;
   logic          active_q;

   logic          restart;
   logic [14:0]   khz, atk_ms, rec_ms, atk_target, rec_target;
   logic [7:0]    atk_mag, rec_mag;
   logic [4:0]    step_limit;
   logic          l_over, r_over, l_under, r_under, over, under;
   logic          atk_run, rec_run, timer_clr, atk_done, rec_done;

   // Register writes; any data on the restart address restarts
   assign restart = wr_en_i && (addr_i == `ALC_ADDR_RESTART);

   always_comb begin
      mode_d  = mode_q;
      thr_d   = thr_q;
      rdata_d = 8'h00;
      if (wr_en_i) begin
         if (addr_i == `ALC_ADDR_MODE_CFG) begin
            mode_d = alc_mode_cfg_s'(wdata_i);
         end else if (addr_i == `ALC_ADDR_THR_TIMES) begin
            thr_d          = alc_thr_cfg_s'(wdata_i);
            thr_d.reserved = 1'b0;
         end
      end
      if (rd_en_i) begin
         if (addr_i == `ALC_ADDR_MODE_CFG) begin
            rdata_d = mode_q;
         end else if (addr_i == `ALC_ADDR_THR_TIMES) begin
            rdata_d = thr_q;
         end else if (addr_i == `ALC_ADDR_RESTART) begin
            rdata_d = gain_q;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         mode_q  <= alc_mode_cfg_s'(`ALC_MODE_RST);
         thr_q   <= alc_thr_cfg_s'(`ALC_THR_RST);
         rdata_q <= 8'h00;
      end else begin
         mode_q  <= mode_d;
         thr_q   <= thr_d;
         rdata_q <= rdata_d;
      end
   end

   // Field decoding into thresholds, times and limits
   always_comb begin
      // Reserved rate code falls back to 48 kHz rather than stalling timers
      case (mode_q.adc_rate_select)
         2'b00:   khz = `ALC_RATE_96_KHZ;
         2'b01:   khz = `ALC_RATE_48_KHZ;
         2'b10:   khz = `ALC_RATE_32_KHZ;
         default: khz = `ALC_RATE_48_KHZ;
      endcase
      case (mode_q.recovery_count_limit)
         2'b00:   step_limit = `ALC_LIMIT_3;
         2'b01:   step_limit = `ALC_LIMIT_7;
         2'b10:   step_limit = `ALC_LIMIT_15;
         default: step_limit = `ALC_LIMIT_31;
      endcase
      case (thr_q.recovery_threshold)
         2'b00:   rec_mag = `ALC_REC_THR_2_DB;
         2'b01:   rec_mag = `ALC_REC_THR_3_DB;
         2'b10:   rec_mag = `ALC_REC_THR_4_DB;
         default: rec_mag = `ALC_REC_THR_6_DB;
      endcase
      case (thr_q.attack_threshold)
         2'b00:   atk_mag = `ALC_ATK_THR_0_DB;
         2'b01:   atk_mag = `ALC_ATK_THR_1_DB;
         2'b10:   atk_mag = `ALC_ATK_THR_2_DB;
         default: atk_mag = `ALC_ATK_THR_4_DB;
      endcase
      case (thr_q.recovery_time_select)
         2'b00:   rec_ms = `ALC_REC_32_MS;
         2'b01:   rec_ms = `ALC_REC_64_MS;
         2'b10:   rec_ms = `ALC_REC_128_MS;
         default: rec_ms = `ALC_REC_256_MS;
      endcase
      atk_ms = thr_q.attack_time_select ? `ALC_ATK_LONG_MS : `ALC_ATK_SHORT_MS;
   end

   // Largest product is 256 ms at 96 kHz, fits 15 bits
   assign atk_target = 15'((atk_ms * khz) >> TIME_SHIFT);
   assign rec_target = 15'((rec_ms * khz) >> TIME_SHIFT);

   // Level above attack threshold: headroom at or under its magnitude
   assign l_over  = left_level_i <= atk_mag;
   assign r_over  = right_level_i <= atk_mag;
   assign l_under = left_level_i > rec_mag;
   assign r_under = right_level_i > rec_mag;

   always_comb begin
      if (mode_q.channel_detect_policy) begin
         over  = l_over && r_over;
         under = l_under || r_under;
      end else begin
         over  = l_over || r_over;
         under = l_under && r_under;
      end
   end

   assign timer_clr = restart || (st_q == ALC_ST_OFF) || !mode_q.level_ctrl_enable;
   assign atk_run   = over;
   assign rec_run   = under && !over;

   alc_timer #(
      .CNT_W (15)
   ) u_atk_timer (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .clr_i      (timer_clr),
      .run_i      (atk_run),
      .tick_i     (sample_stb_i),
      .target_i   (atk_target),
      .done_o     (atk_done)
   );

   alc_timer #(
      .CNT_W (15)
   ) u_rec_timer (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .clr_i      (timer_clr),
      .run_i      (rec_run),
      .tick_i     (sample_stb_i),
      .target_i   (rec_target),
      .done_o     (rec_done)
   );

   // Gain state machine
   always_comb begin
      st_d    = st_q;
      gain_d  = gain_q;
      steps_d = steps_q;
      if (restart || !mode_q.level_ctrl_enable) begin
         st_d    = ALC_ST_OFF;
         gain_d  = 8'h00;
         steps_d = 5'h00;
      end else begin
         case (st_q)
            ALC_ST_OFF: begin
               st_d = ALC_ST_RUN;
            end
            ALC_ST_RUN, ALC_ST_EXHAUSTED: begin
               if (atk_done) begin
                  // Attack wins over a coincident recovery step
                  if (gain_q != GAIN_MAX) begin
                     gain_d = gain_q + 8'h01;
                  end
                  steps_d = 5'h00;
                  st_d    = ALC_ST_RUN;
               end else if (rec_done && gain_q != 8'h00) begin
                  case (mode_q.recovery_mode_select)
                     ALC_REC_NORMAL: begin
                        gain_d = gain_q - 8'h01;
                     end
                     ALC_REC_LIMITED: begin
                        if (steps_q < step_limit) begin
                           gain_d  = gain_q - 8'h01;
                           steps_d = steps_q + 5'h01;
                           if (steps_q + 5'h01 == step_limit) begin
                              st_d = ALC_ST_EXHAUSTED;
                           end
                        end
                     end
                     default: begin
                        gain_d = gain_q;
                     end
                  endcase
               end
            end
            default: begin
               st_d = ALC_ST_OFF;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         st_q     <= ALC_ST_OFF;
         gain_q   <= 8'h00;
         steps_q  <= 5'h00;
         active_q <= 1'b0;
      end else begin
         st_q     <= st_d;
         gain_q   <= gain_d;
         steps_q  <= steps_d;
         active_q <= (st_d != ALC_ST_OFF);
      end
   end

   assign rdata_o             = rdata_q;
   assign gain_reduction_o    = gain_q;
   assign level_ctrl_active_o = active_q;

   // Checks
   sequence s_restart_wr;
      wr_en_i && (addr_i == `ALC_ADDR_RESTART);
   endsequence

   sequence s_mode_wr;
      wr_en_i && (addr_i == `ALC_ADDR_MODE_CFG);
   endsequence

   sequence s_mode_rd;
      rd_en_i && (addr_i == `ALC_ADDR_MODE_CFG);
   endsequence

   sequence s_cleared;
      (gain_q == 8'h00) && (steps_q == 5'h00) && (st_q == ALC_ST_OFF);
   endsequence

   a_restart_clears_all: assert property (
      @(posedge core_clk_i) disable iff (sys_rst_i) s_restart_wr |=> s_cleared)
      else $error("restart did not clear gain state");

   a_restart_keeps_cfg: assert property (
      @(posedge core_clk_i) disable iff (sys_rst_i)
      s_restart_wr |=> (mode_q == $past(mode_q)) && (thr_q == $past(thr_q)))
      else $error("restart write altered configuration");

   a_read_gives_gain: assert property (
      @(posedge core_clk_i) disable iff (sys_rst_i)
      rd_en_i && (addr_i == `ALC_ADDR_RESTART) |=> rdata_o == $past(gain_q))
      else $error("restart register read is not gain reduction");

   a_mode_read_back: assert property (
      @(posedge core_clk_i) disable iff (sys_rst_i)
      s_mode_wr ##1 !wr_en_i ##1 s_mode_rd |=> rdata_o == $past(wdata_i, 3))
      else $error("mode register layout lost on read back");

   a_disable_idles: assert property (
      @(posedge core_clk_i) disable iff (sys_rst_i)
      !mode_q.level_ctrl_enable [*2] |-> (gain_q == 8'h00) && !level_ctrl_active_o)
      else $error("level control active while disabled");

   a_either_attack: assert property (
      @(posedge core_clk_i) disable iff (sys_rst_i)
      !mode_q.channel_detect_policy && (l_over || r_over) |-> atk_run)
      else $error("single channel over limit did not arm attack");

   a_both_attack: assert property (
      @(posedge core_clk_i) disable iff (sys_rst_i)
      mode_q.channel_detect_policy && !(l_over && r_over) |-> !atk_run)
      else $error("attack armed without both channels over limit");

   a_attack_raises: assert property (
      @(posedge core_clk_i) disable iff (sys_rst_i)
      atk_done && !restart && mode_q.level_ctrl_enable && (st_q != ALC_ST_OFF)
      && (gain_q != GAIN_MAX) |=> gain_q == $past(gain_q) + 8'h01)
      else $error("attack expiry did not raise gain reduction");

   a_no_recovery: assert property (
      @(posedge core_clk_i) disable iff (sys_rst_i)
      (mode_q.recovery_mode_select == ALC_REC_NONE) && !restart && mode_q.level_ctrl_enable
      |=> gain_q >= $past(gain_q))
      else $error("gain recovered with recovery off");

   a_step_limit: assert property (
      @(posedge core_clk_i) disable iff (sys_rst_i)
      (st_q == ALC_ST_EXHAUSTED) && !atk_done && !restart && mode_q.level_ctrl_enable
      |=> gain_q == $past(gain_q))
      else $error("limited recovery exceeded its step limit");

   a_reserved_zero: assert property (
      @(posedge core_clk_i) disable iff (sys_rst_i)
      rd_en_i && (addr_i == `ALC_ADDR_THR_TIMES) |=> !rdata_o[`ALC_RSVD_POS])
      else $error("reserved threshold bit reads one");

   a_attack_time: assert property (
      @(posedge core_clk_i) disable iff (sys_rst_i)
      atk_target == (((thr_q.attack_time_select ? 4 : 1) * int'(khz)) >> TIME_SHIFT))
      else $error("attack time target wrong");
endmodule
`default_nettype wire

/* File: alc_regs_tb.sv */
// Purpose: Self-checking bench for the level control register block
// Assumes: TIME_SHIFT of 4 divides every timer target by sixteen
// Notes:   Inputs move on the falling edge; expected register and gain values live in integers
`include "alc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int SHIFT      = 4;
   localparam int CYCLE_MAX  = 40000;
   localparam int RATE[3]    = '{96, 48, 32};
   localparam int ATK_MS[2]  = '{1, 4};
   localparam int REC_MS[4]  = '{32, 64, 128, 256};
   localparam int ATK_MAG[4] = '{0, 1, 2, 4};
   localparam int REC_MAG[4] = '{2, 3, 4, 6};
   localparam int LIM[4]     = '{3, 7, 15, 31};
   localparam int POL[4]     = '{0, 0, 1, 1};
   localparam int LEFT[4]    = '{0, 1, 0, 0};
   localparam int RIGHT[4]   = '{1, 0, 1, 0};
   localparam int DELTA[4]   = '{1, 1, 0, 1};

   logic        core_clk_i;
   logic        sys_rst_i;
   logic        wr_en_i;
   logic        rd_en_i;
   logic [6:0]  addr_i;
   logic [7:0]  wdata_i;
   logic [7:0]  rdata_o;
   logic        sample_stb_i;
   logic [7:0]  left_level_i;
   logic [7:0]  right_level_i;
   logic [7:0]  gain_reduction_o;
   logic        level_ctrl_active_o;
   int          miscompares;
   int          cmp_count;
   int          cycles = 0;
   logic [31:0] lfsr;
   int          mode_m;
   int          thr_m;
   int          gain_m;

   alc_regs #(
      .TIME_SHIFT (SHIFT)
   ) uut (
      .core_clk_i          (core_clk_i),
      .sys_rst_i           (sys_rst_i),
      .wr_en_i             (wr_en_i),
      .rd_en_i             (rd_en_i),
      .addr_i              (addr_i),
      .wdata_i             (wdata_i),
      .rdata_o             (rdata_o),
      .sample_stb_i        (sample_stb_i),
      .left_level_i        (left_level_i),
      .right_level_i       (right_level_i),
      .gain_reduction_o    (gain_reduction_o),
      .level_ctrl_active_o (level_ctrl_active_o)
   );

   always #2.5 core_clk_i = ~core_clk_i;

   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   function automatic int tgt(input int ms, input int khz);
      return (ms * khz) >> SHIFT;
   endfunction

   task automatic end_of_test;
      if (miscompares == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Model follows every write; a disable also drops the gain
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge core_clk_i);
      wr_en_i = 1'b1;
      addr_i  = a;
      wdata_i = d;
      @(negedge core_clk_i);
      wr_en_i = 1'b0;
      if (a == `ALC_ADDR_MODE_CFG) begin
         mode_m = d;
         if (d[0] == 1'b0) gain_m = 0;
      end else if (a == `ALC_ADDR_THR_TIMES) begin
         thr_m = d & 8'h7F;
      end else if (a == `ALC_ADDR_RESTART) begin
         gain_m = 0;
      end
   endtask

   // Read data stands one cycle only, then returns to zero
   task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
      @(negedge core_clk_i);
      rd_en_i = 1'b1;
      addr_i  = a;
      @(negedge core_clk_i);
      rd_en_i = 1'b0;
      chk(rdata_o, e);
      @(negedge core_clk_i);
      chk(rdata_o, 8'h00);
   endtask

   task automatic restart;
      lfsr = lfsr_next(lfsr);
      wr(`ALC_ADDR_RESTART, lfsr[7:0]);
   endtask

   task automatic lv(input int l, input int r);
      @(negedge core_clk_i);
      left_level_i  = 8'(l);
      right_level_i = 8'(r);
   endtask

   task automatic strobes(input int n);
      repeat (n) begin
         @(negedge core_clk_i);
         sample_stb_i = 1'b1;
         @(negedge core_clk_i);
         sample_stb_i = 1'b0;
      end
   endtask

   // Last strobe raises the done pulse; gain moves one edge later
   task automatic step(input int t, input int d);
      strobes(t - 1);
      repeat (2) @(negedge core_clk_i);
      chk(gain_reduction_o, 8'(gain_m));
      strobes(1);
      chk(gain_reduction_o, 8'(gain_m));
      gain_m = gain_m + d;
      if (gain_m < 0) gain_m = 0;
      if (gain_m > 255) gain_m = 255;
      @(negedge core_clk_i);
      chk(gain_reduction_o, 8'(gain_m));
   endtask

   // A neutral level first, so the timer starts from zero
   task automatic go(input int n, input int l, input int r, input int t, input int d);
      lv(n, n);
      lv(l, r);
      step(t, d);
   endtask

   always @(posedge core_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == CYCLE_MAX) begin
         chk(8'h01, 8'h00);
         end_of_test();
      end
   end

   initial begin
      core_clk_i    = 1'b0;
      sys_rst_i     = 1'b1;
      wr_en_i       = 1'b0;
      rd_en_i       = 1'b0;
      addr_i        = 7'h00;
      wdata_i       = 8'h00;
      sample_stb_i  = 1'b0;
      left_level_i  = 8'hFF;
      right_level_i = 8'hFF;
      miscompares   = 0;
      cmp_count     = 0;
      lfsr          = 32'h6AF8;
      mode_m        = 0;
      thr_m         = 0;
      gain_m        = 0;
      repeat (5) @(posedge core_clk_i);
      @(negedge core_clk_i);
      sys_rst_i = 1'b0;
      chk(gain_reduction_o, 8'h00);
      chk({7'h00, level_ctrl_active_o}, 8'h00);
      rd_chk(`ALC_ADDR_RESTART, 8'h00);
      repeat (12) begin
         lfsr = lfsr_next(lfsr);
         wr(`ALC_ADDR_THR_TIMES, lfsr[15:8]);
         wr(7'h7E, lfsr[23:16]);
         // Reserved rate code never written
         wr(`ALC_ADDR_MODE_CFG, {lfsr[7] & ~lfsr[6], lfsr[6:0]});
         rd_chk(`ALC_ADDR_MODE_CFG, 8'(mode_m));
         rd_chk(`ALC_ADDR_THR_TIMES, 8'(thr_m));
         rd_chk(7'h7E, 8'h00);
      end
      for (int r = 0; r < 3; r++) begin
         for (int t = 0; t < 2; t++) begin
            wr(`ALC_ADDR_MODE_CFG, 8'((r << 6) | 1));
            wr(`ALC_ADDR_THR_TIMES, 8'(8'h60 | t));
            restart();
            go(1, 0, 0, tgt(ATK_MS[t], RATE[r]), 1);
            rd_chk(`ALC_ADDR_RESTART, 8'(gain_m));
            restart();
            chk(gain_reduction_o, 8'h00);
            chk({7'h00, level_ctrl_active_o}, 8'h00);
            @(negedge core_clk_i);
            chk({7'h00, level_ctrl_active_o}, 8'h01);
            rd_chk(`ALC_ADDR_MODE_CFG, 8'(mode_m));
         end
      end
      wr(`ALC_ADDR_MODE_CFG, 8'h81);
      for (int a = 0; a < 4; a++) begin
         wr(`ALC_ADDR_THR_TIMES, 8'(8'h60 | (a << 3)));
         restart();
         go(ATK_MAG[a] + 1, ATK_MAG[a] + 1, ATK_MAG[a] + 1, 2, 0);
         go(ATK_MAG[a] + 1, ATK_MAG[a], ATK_MAG[a], 2, 1);
      end
      for (int p = 0; p < 4; p++) begin
         wr(`ALC_ADDR_MODE_CFG, 8'(8'h81 | (POL[p] << 1)));
         wr(`ALC_ADDR_THR_TIMES, 8'h60);
         restart();
         go(1, LEFT[p], RIGHT[p], 2, DELTA[p]);
      end
      // Disable while gain is held must drop it and keep it down
      wr(`ALC_ADDR_MODE_CFG, 8'h80);
      go(1, 0, 0, 2, 0);
      chk({7'h00, level_ctrl_active_o}, 8'h00);
      wr(`ALC_ADDR_MODE_CFG, 8'h85);
      for (int c = 0; c < 4; c++) begin
         wr(`ALC_ADDR_THR_TIMES, 8'(8'h60 | (c << 1)));
         restart();
         go(1, 0, 0, 2, 1);
         go(1, 7, 7, tgt(REC_MS[c], 32), -1);
      end
      for (int c = 0; c < 4; c++) begin
         wr(`ALC_ADDR_THR_TIMES, 8'(c << 5));
         restart();
         go(1, 0, 0, 2, 1);
         go(1, REC_MAG[c], REC_MAG[c], 64, 0);
         go(1, REC_MAG[c] + 1, REC_MAG[c] + 1, 64, -1);
      end
      wr(`ALC_ADDR_THR_TIMES, 8'h60);
      for (int m = 0; m < 4; m++) begin
         wr(`ALC_ADDR_MODE_CFG, 8'(8'h89 | (m << 4)));
         restart();
         repeat (LIM[m] + 1) go(1, 0, 0, 2, 1);
         for (int k = 0; k <= LIM[m]; k++) begin
            go(1, 7, 7, 64, (k < LIM[m]) ? -1 : 0);
         end
      end
      wr(`ALC_ADDR_MODE_CFG, 8'h81);
      restart();
      go(1, 0, 0, 2, 1);
      go(1, 7, 7, 64, 0);
      end_of_test();
   end
endmodule
`default_nettype wire
